//--- common/rst_seq_pkg.sv
`default_nettype none
package rst_seq_pkg;
  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_CAUSE = 12'h000;
  localparam logic [11:0] ADDR_CONFIG = 12'h004;
  localparam logic [11:0] ADDR_WDOG_CLR = 12'h008;

  // reset_cause_flags bit positions
  localparam int POS_POR = 7;
  localparam int POS_PIN = 6;
  localparam int POS_WDOG = 5;
  localparam int POS_BAD_OP = 4;
  localparam int POS_BAD_ADDR = 3;
  localparam int POS_MODRST = 2;
  localparam int POS_LOW_SUP = 1;
  localparam logic [7:0] CAUSE_POR_VALUE = 8'h80;

  // configuration bit positions
  localparam int POS_SHORT_REC = 0;
  localparam int POS_STOP_EN = 1;
  localparam int POS_OSC_IN_STOP = 2;
  localparam int POS_LOW_SUP_RST_EN = 3;
  localparam int POS_BUS_FAST_SEL = 4;
  localparam int CONFIG_W = 5;
  localparam logic [4:0] CONFIG_RST = 5'h08;

  // ----------------------------------------------------------------
  // vectors (high-byte address of each pair)
  // ----------------------------------------------------------------
  localparam logic [15:0] VEC_RESET = 16'hfffe;
  localparam logic [15:0] VEC_RESET_MON = 16'hfefe;
  localparam logic [15:0] VEC_IRQ = 16'hfffa;
  localparam logic [15:0] VEC_BREAK = 16'hfffc;
  localparam logic [15:0] VEC_KBD = 16'hffde;
  localparam logic [15:0] VEC_TIMEBASE = 16'hffdc;

  // ----------------------------------------------------------------
  // timing, in reference clock cycles, or in ns where the name ends in NS (reference clock is i_clk)
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int STAB_CYCLES = 4096;
  localparam int DRIVE_CYCLES = 32;
  localparam int HOLD_CYCLES = 32;
  localparam int SHORT_REC_CYCLES = 32;
  localparam int MIN_PULSE_NS = 100;
  localparam int MIN_PULSE_CYCLES =
    (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 12;
  localparam logic [11:0] STAB_LAST = 12'(STAB_CYCLES - 1);
  localparam logic [11:0] DRIVE_LAST = 12'(DRIVE_CYCLES - 1);
  localparam logic [11:0] HOLD_LAST = 12'(HOLD_CYCLES - 1);
  localparam logic [11:0] SHORT_LAST = 12'(SHORT_REC_CYCLES - 1);
  localparam logic [11:0] PULSE_LAST = 12'(MIN_PULSE_CYCLES - 1);

  // pin synchroniser lanes
  localparam int SYNC_N = 5;
  localparam int LANE_RST = 0;
  localparam int LANE_LOW_SUP = 1;
  localparam int LANE_IRQ = 2;
  localparam int LANE_KBD = 3;
  localparam int LANE_MON = 4;
  // idle level per lane: line, irq and keyboard high; supply, strap low
  localparam logic [4:0] SYNC_IDLE = 5'h0d;

  typedef enum logic [6:0] {
    ST_RUN = 7'b0000001,
    ST_LOW_SUP = 7'b0000010,
    ST_STAB = 7'b0000100,
    ST_DRIVE = 7'b0001000,
    ST_HOLD = 7'b0010000,
    ST_EXT = 7'b0100000,
    ST_STOP = 7'b1000000
  } seq_state_t;
endpackage
`default_nettype wire

//--- rtl/rst_seq.sv
// The address map and register access over APB were decided locally.
`timescale 1ns/100ps
`default_nettype none
module rst_seq (
  // clock and power-on reset
  input wire logic i_clk,
  input wire logic i_rst,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // shared reset line, open drain
  input wire logic i_rst_line_n,
  output logic o_rst_line_out,
  output logic o_rst_line_oe_n,
  // pins
  input wire logic i_low_supply,
  input wire logic i_irq_n,
  input wire logic i_kbd_n,
  input wire logic i_monitor_mode,
  // core events (same clock)
  input wire logic i_wdog_overflow,
  input wire logic i_bad_opcode,
  input wire logic i_stop_exec,
  input wire logic i_bad_fetch_addr,
  input wire logic i_break_evt,
  input wire logic i_timebase_roll,
  // core control
  output logic o_cpu_rst,
  output logic o_clk_run,
  output logic o_vec_fetch,
  output logic [15:0] o_vector,
  output logic o_bus_div4_sel,
  output logic o_in_stop,
  output logic o_serial_abort,
  output logic o_wdog_clear
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [rst_seq_pkg::SYNC_N-1:0] pins_raw, meta_reg, sync_reg, sync_d_reg;
  assign pins_raw = {i_monitor_mode, i_kbd_n, i_irq_n, i_low_supply,
                     i_rst_line_n};

  for (genvar gi = 0; gi < rst_seq_pkg::SYNC_N; gi++) begin : g_sync
    // lanes reset to their idle level, so no false edge follows reset
    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
        meta_reg[gi] <= rst_seq_pkg::SYNC_IDLE[gi];
        sync_reg[gi] <= rst_seq_pkg::SYNC_IDLE[gi];
        sync_d_reg[gi] <= rst_seq_pkg::SYNC_IDLE[gi];
      end else begin
        meta_reg[gi] <= pins_raw[gi];
        sync_reg[gi] <= meta_reg[gi];
        sync_d_reg[gi] <= sync_reg[gi];
      end
    end
  end

  logic line_low, low_sup, irq_fall, kbd_fall, mon_mode;
  assign line_low = ~sync_reg[rst_seq_pkg::LANE_RST];
  assign low_sup = sync_reg[rst_seq_pkg::LANE_LOW_SUP];
  assign irq_fall = sync_d_reg[rst_seq_pkg::LANE_IRQ] &
                    ~sync_reg[rst_seq_pkg::LANE_IRQ];
  assign kbd_fall = sync_d_reg[rst_seq_pkg::LANE_KBD] &
                    ~sync_reg[rst_seq_pkg::LANE_KBD];
  // monitor strap is active high; reset value of the lane is ignored
  assign mon_mode = sync_reg[rst_seq_pkg::LANE_MON];

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  logic [7:0] cause_reg;
  logic [rst_seq_pkg::CONFIG_W-1:0] config_reg;
  logic access, wr_done, rd_done, hit_cause, hit_config, hit_wdog, mapped;

  assign access = i_psel & i_penable & o_pready;
  assign wr_done = access & i_pwrite;
  assign rd_done = access & ~i_pwrite;
  assign hit_cause = (i_paddr == rst_seq_pkg::ADDR_CAUSE);
  assign hit_config = (i_paddr == rst_seq_pkg::ADDR_CONFIG);
  assign hit_wdog = (i_paddr == rst_seq_pkg::ADDR_WDOG_CLR);
  assign mapped = hit_cause | hit_config | hit_wdog;

  // one wait state: ready in the second access cycle
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= i_psel & i_penable & ~o_pready;
      // cause register is read-only, writes to it are errors
      o_pslverr <= i_psel & i_penable & ~o_pready &
                   (~mapped | (hit_cause & i_pwrite));
    end
  end

  // read data sampled in setup, so a same-edge flag set shows next read
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_prdata <= 32'h0;
    end else if (i_psel & ~i_penable & ~i_pwrite) begin
      o_prdata <= hit_cause ? {24'h0, cause_reg} :
                  hit_config ? {27'h0, config_reg} : 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  rst_seq_pkg::seq_state_t state_reg;
  logic [rst_seq_pkg::CNT_W-1:0] cnt_reg;
  logic [rst_seq_pkg::CNT_W-1:0] pulse_reg;
  logic internal_reg;
  logic [15:0] wake_vec_reg;
  logic in_reset, low_sup_rst, ext_rst, int_src, bad_op, wake;
  logic [15:0] wake_vec;
  logic [rst_seq_pkg::CNT_W-1:0] rec_last;

  assign in_reset = (state_reg != rst_seq_pkg::ST_RUN) &&
                    (state_reg != rst_seq_pkg::ST_STOP);
  // detector stays armed in wait and stop
  assign low_sup_rst = low_sup &
                       config_reg[rst_seq_pkg::POS_LOW_SUP_RST_EN];
  // line must stay low for the minimum pulse time
  assign ext_rst = line_low & (pulse_reg == rst_seq_pkg::PULSE_LAST);
  // stop while disabled counts as an illegal opcode
  assign bad_op = i_bad_opcode |
                  (i_stop_exec & ~config_reg[rst_seq_pkg::POS_STOP_EN]);
  // only opcode fetches reach this block as a reset source
  assign int_src = i_wdog_overflow | bad_op | i_bad_fetch_addr;
  // timebase wake needs the oscillator alive in stop
  assign wake = irq_fall | kbd_fall | i_break_evt |
                (i_timebase_roll &
                 config_reg[rst_seq_pkg::POS_OSC_IN_STOP]);
  assign rec_last = config_reg[rst_seq_pkg::POS_SHORT_REC] ?
                    rst_seq_pkg::SHORT_LAST : rst_seq_pkg::STAB_LAST;

  assign wake_vec = irq_fall ? rst_seq_pkg::VEC_IRQ :
                    kbd_fall ? rst_seq_pkg::VEC_KBD :
                    i_break_evt ? rst_seq_pkg::VEC_BREAK :
                    rst_seq_pkg::VEC_TIMEBASE;

  // low-pulse width counter, saturating at the minimum
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pulse_reg <= '0;
    end else if (!line_low || o_rst_line_oe_n == 1'b0) begin
      pulse_reg <= '0;
    end else if (pulse_reg != rst_seq_pkg::PULSE_LAST) begin
      pulse_reg <= pulse_reg + 12'h001;
    end
  end

  // clocks held, line low for 4096 cycles
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= rst_seq_pkg::ST_STAB;
      cnt_reg <= '0;
      internal_reg <= 1'b1;
    end else if (low_sup_rst) begin
      // line held low while supply is under trip level
      state_reg <= rst_seq_pkg::ST_LOW_SUP;
      cnt_reg <= '0;
      internal_reg <= 1'b1;
    end else begin
      unique case (state_reg)
        rst_seq_pkg::ST_RUN: begin
          cnt_reg <= '0;
          if (ext_rst) begin
            state_reg <= rst_seq_pkg::ST_EXT;
            internal_reg <= 1'b0;
          end else if (int_src) begin
            state_reg <= rst_seq_pkg::ST_DRIVE;
            internal_reg <= 1'b1;
          end else if (i_stop_exec) begin
            // recovery counter cleared on stop entry
            state_reg <= rst_seq_pkg::ST_STOP;
          end
        end
        rst_seq_pkg::ST_LOW_SUP: begin
          state_reg <= rst_seq_pkg::ST_STAB;
          cnt_reg <= '0;
        end
        rst_seq_pkg::ST_STAB: begin
          cnt_reg <= cnt_reg + 12'h001;
          if (cnt_reg == rst_seq_pkg::STAB_LAST) begin
            state_reg <= rst_seq_pkg::ST_DRIVE;
            cnt_reg <= '0;
          end
        end
        rst_seq_pkg::ST_DRIVE: begin
          cnt_reg <= cnt_reg + 12'h001;
          if (cnt_reg == rst_seq_pkg::DRIVE_LAST) begin
            state_reg <= rst_seq_pkg::ST_HOLD;
            cnt_reg <= '0;
          end
        end
        rst_seq_pkg::ST_HOLD: begin
          // 32 more cycles in reset after release
          cnt_reg <= cnt_reg + 12'h001;
          if (cnt_reg == rst_seq_pkg::HOLD_LAST) begin
            state_reg <= rst_seq_pkg::ST_RUN;
            cnt_reg <= '0;
          end
        end
        rst_seq_pkg::ST_EXT: begin
          // external reset lasts while the line is low, then the hold
          cnt_reg <= '0;
          if (!line_low) begin
            state_reg <= rst_seq_pkg::ST_HOLD;
          end
        end
        rst_seq_pkg::ST_STOP: begin
          if (ext_rst) begin
            state_reg <= rst_seq_pkg::ST_EXT;
            internal_reg <= 1'b0;
            cnt_reg <= '0;
          end else if (cnt_reg != '0) begin
            // clocks stay off until terminal count
            cnt_reg <= cnt_reg + 12'h001;
            if (cnt_reg == rec_last) begin
              state_reg <= rst_seq_pkg::ST_RUN;
              cnt_reg <= '0;
            end
          end else if (wake) begin
            cnt_reg <= 12'h001;
          end
        end
        default: begin
          state_reg <= rst_seq_pkg::ST_STAB;
          cnt_reg <= '0;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wake_vec_reg <= rst_seq_pkg::VEC_RESET;
    end else if (state_reg == rst_seq_pkg::ST_STOP && cnt_reg == '0 &&
                 wake) begin
      wake_vec_reg <= wake_vec;
    end
  end

  // ----------------------------------------------------------------
  // reset cause flags
  // ----------------------------------------------------------------
  logic [7:0] cause_set;
  logic pin_late;

  // line still low when sampled at the end of the hold
  assign pin_late = (state_reg == rst_seq_pkg::ST_HOLD) &&
                    (cnt_reg == rst_seq_pkg::HOLD_LAST) &&
                    internal_reg && line_low;

  always_comb begin
    cause_set = 8'h0;
    cause_set[rst_seq_pkg::POS_PIN] = ((state_reg == rst_seq_pkg::ST_RUN ||
      state_reg == rst_seq_pkg::ST_STOP) && ext_rst) || pin_late;
    if (!low_sup_rst && state_reg == rst_seq_pkg::ST_RUN && !ext_rst) begin
      cause_set[rst_seq_pkg::POS_WDOG] = i_wdog_overflow;
      cause_set[rst_seq_pkg::POS_BAD_OP] = bad_op;
      cause_set[rst_seq_pkg::POS_BAD_ADDR] = i_bad_fetch_addr;
    end
    cause_set[rst_seq_pkg::POS_LOW_SUP] = low_sup_rst;
  end

  // power-on value sets only the power-on flag
  // flags accumulate; a read of the cause register clears, set wins
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cause_reg <= rst_seq_pkg::CAUSE_POR_VALUE;
    end else if (rd_done && hit_cause) begin
      cause_reg <= cause_set;
    end else begin
      cause_reg <= cause_reg | cause_set;
    end
  end

  // ----------------------------------------------------------------
  // configuration
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      config_reg <= rst_seq_pkg::CONFIG_RST;
    end else if (in_reset) begin
      // bus clock select falls back to divide by four
      config_reg[rst_seq_pkg::POS_BUS_FAST_SEL] <= 1'b0;
    end else if (wr_done && hit_config) begin
      config_reg <= i_pwdata[rst_seq_pkg::CONFIG_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic drive_line;

  // the line is pulled in stabilisation, low supply and drive
  assign drive_line = (state_reg == rst_seq_pkg::ST_STAB) ||
                      (state_reg == rst_seq_pkg::ST_LOW_SUP) ||
                      (state_reg == rst_seq_pkg::ST_DRIVE);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rst_line_out <= 1'b0;
      o_rst_line_oe_n <= 1'b0;
      o_cpu_rst <= 1'b1;
      o_clk_run <= 1'b0;
      o_in_stop <= 1'b0;
      o_bus_div4_sel <= 1'b1;
    end else begin
      o_rst_line_out <= 1'b0;
      o_rst_line_oe_n <= ~drive_line;
      // core held in reset, current instruction abandoned
      o_cpu_rst <= in_reset;
      // clocks stopped during stabilisation and stop recovery
      o_clk_run <= (state_reg != rst_seq_pkg::ST_STAB) &&
                   (state_reg != rst_seq_pkg::ST_LOW_SUP) &&
                   (state_reg != rst_seq_pkg::ST_STOP);
      o_in_stop <= (state_reg == rst_seq_pkg::ST_STOP);
      o_bus_div4_sel <= in_reset | ~config_reg[rst_seq_pkg::POS_BUS_FAST_SEL];
    end
  end

  // vector pair chosen as the sequence returns to run
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_vec_fetch <= 1'b0;
      o_vector <= rst_seq_pkg::VEC_RESET;
    end else begin
      o_vec_fetch <= 1'b0;
      if (state_reg == rst_seq_pkg::ST_HOLD &&
          cnt_reg == rst_seq_pkg::HOLD_LAST) begin
        o_vec_fetch <= 1'b1;
        o_vector <= mon_mode ? rst_seq_pkg::VEC_RESET_MON :
                               rst_seq_pkg::VEC_RESET;
      end else if (state_reg == rst_seq_pkg::ST_STOP &&
                   cnt_reg == rec_last && cnt_reg != '0 && !ext_rst) begin
        o_vec_fetch <= 1'b1;
        o_vector <= wake_vec_reg;
      end
    end
  end

  // only a reset leaving stop aborts the serial transfer
  // any write to the clear location restarts the watchdog
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_serial_abort <= 1'b0;
      o_wdog_clear <= 1'b0;
    end else begin
      o_serial_abort <= (state_reg == rst_seq_pkg::ST_STOP) &&
                        (ext_rst || low_sup_rst);
      o_wdog_clear <= wr_done & hit_wdog;
    end
  end

endmodule
`default_nettype wire

//--- testbench/rst_seq_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module rst_seq_asserts (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // watched ports
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic i_low_supply,
  input wire logic i_monitor_mode,
  input wire logic o_rst_line_oe_n,
  input wire logic o_cpu_rst,
  input wire logic o_clk_run,
  input wire logic o_vec_fetch,
  input wire logic [15:0] o_vector,
  input wire logic o_bus_div4_sel,
  input wire logic o_in_stop,
  input wire logic o_wdog_clear
);
  logic [5:0] drv_cnt;
  logic [12:0] stab_cnt;
  logic from_rst;
  logic take;
  assign take = i_psel && i_penable && o_pready && i_pwrite;
  // ----------------------------
  // helper counters
  // ----------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      drv_cnt <= '0;
      stab_cnt <= '0;
      from_rst <= 1'b1;
    end else begin
      drv_cnt <= o_rst_line_oe_n ? '0 : drv_cnt + {5'h00, o_clk_run};
      // low supply time is open ended: count only after it recovers
      stab_cnt <= (o_rst_line_oe_n || i_low_supply) ? '0 :
        stab_cnt + {12'h000, !o_clk_run};
      from_rst <= !o_vec_fetch && (o_cpu_rst || from_rst);
    end
  end
  // ----------------------------
  // properties
  // ----------------------------
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  drive_len_a:
    assert property ($rose(o_rst_line_oe_n) |-> drv_cnt == 6'h20)
    else $error("reset line drive length wrong");
  hold_len_a:
    assert property ($rose(o_rst_line_oe_n) |->
      o_cpu_rst [*8] ##[23:27] o_vec_fetch)
    else $error("reset hold length wrong");
  stab_len_a:
    assert property ($rose(o_clk_run) && !o_rst_line_oe_n |->
      stab_cnt >= 13'h1000 && stab_cnt <= 13'h1005)
    else $error("stabilisation length wrong");
  reset_vec_a:
    assert property (o_vec_fetch && from_rst |-> o_vector ==
      (i_monitor_mode ? rst_seq_pkg::VEC_RESET_MON : rst_seq_pkg::VEC_RESET))
    else $error("reset vector wrong");
  bus_div4_a:
    assert property (o_cpu_rst |-> o_bus_div4_sel)
    else $error("bus clock not ref div 4 in reset");
  stop_gate_a:
    assert property ($rose(o_in_stop) |-> !o_clk_run [*8])
    else $error("clocks run in stop");
  apb_wait_a:
    assert property (i_psel && i_penable && !o_pready |=> o_pready)
    else $error("apb answer late");
  cause_ro_a:
    assert property (take && i_paddr == rst_seq_pkg::ADDR_CAUSE |-> o_pslverr)
    else $error("cause register write accepted");
  wdog_clr_a:
    assert property (take && i_paddr == rst_seq_pkg::ADDR_WDOG_CLR |->
      ##[0:2] o_wdog_clear)
    else $error("watchdog clear missing");
  low_sup_a:
    assert property (i_low_supply ##1 i_low_supply |-> ##[0:4] !o_rst_line_oe_n)
    else $error("line not driven in low supply");
endmodule
bind rst_seq rst_seq_asserts u_chk (
  .i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .i_low_supply(i_low_supply),
  .i_monitor_mode(i_monitor_mode), .o_rst_line_oe_n(o_rst_line_oe_n),
  .o_cpu_rst(o_cpu_rst), .o_clk_run(o_clk_run), .o_vec_fetch(o_vec_fetch),
  .o_vector(o_vector), .o_bus_div4_sel(o_bus_div4_sel),
  .o_in_stop(o_in_stop), .o_wdog_clear(o_wdog_clear)
);
`default_nettype wire

//--- testbench/rst_line_model.sv
`timescale 1ns/100ps
`default_nettype none
module rst_line_model (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // pull request from the bench
  input wire logic i_pull,
  input wire logic [7:0] i_len,
  // device side of the line
  input wire logic i_oe_n,
  output logic o_line_n
);
  logic [7:0] left;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) left <= '0;
    else if (i_pull) left <= i_len;
    else if (left != 8'h00) left <= left - 8'h01;
  end
  // pull-up: high only when nobody sinks the line
  assign o_line_n = i_oe_n && (left == 8'h00);
endmodule
`default_nettype wire

//--- testbench/tb_rst_seq.sv
`timescale 1ns/100ps
`default_nettype none
module tb_rst_seq;
  logic i_clk, i_rst, psel, pen, pwr, err, pready, pslverr, line_n, oe_n;
  logic lowsup, irq_n, kbd_n, mon, wdog, badop, stopx, badad, brk, tbr;
  logic pull, cpu_rst, clk_run, vf, div4, in_stop, sabort, wclr, seen_ab;
  logic [7:0] plen;
  logic [11:0] paddr;
  logic [15:0] vec;
  logic [31:0] pwdata, prdata, rd;
  int fails, num_checks, n;
  int wk[4] = '{6, 7, 4, 5};
  int pos[4] = '{rst_seq_pkg::POS_WDOG, rst_seq_pkg::POS_BAD_OP,
    rst_seq_pkg::POS_BAD_OP, rst_seq_pkg::POS_BAD_ADDR};
  logic [15:0] wv[4] = '{rst_seq_pkg::VEC_IRQ, rst_seq_pkg::VEC_KBD,
    rst_seq_pkg::VEC_BREAK, rst_seq_pkg::VEC_TIMEBASE};
  rst_seq DUT (
    .i_clk(i_clk), .i_rst(i_rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_rst_line_n(line_n),
    .o_rst_line_out(), .o_rst_line_oe_n(oe_n), .i_low_supply(lowsup),
    .i_irq_n(irq_n), .i_kbd_n(kbd_n), .i_monitor_mode(mon),
    .i_wdog_overflow(wdog), .i_bad_opcode(badop), .i_stop_exec(stopx),
    .i_bad_fetch_addr(badad), .i_break_evt(brk), .i_timebase_roll(tbr),
    .o_cpu_rst(cpu_rst), .o_clk_run(clk_run), .o_vec_fetch(vf),
    .o_vector(vec), .o_bus_div4_sel(div4), .o_in_stop(in_stop),
    .o_serial_abort(sabort), .o_wdog_clear(wclr)
  );
  rst_line_model u_line (.i_clk(i_clk), .i_rst(i_rst), .i_pull(pull),
    .i_len(plen), .i_oe_n(oe_n), .o_line_n(line_n));
  // ----------------------------
  // tasks
  // ----------------------------
  task automatic print_verdict();
    if (fails == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    pen <= 1'b1;
    do @(posedge i_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic cause(input logic [31:0] e);
    bus(1'b0, rst_seq_pkg::ADDR_CAUSE, 32'h0);
    chk(rd, e);
  endtask
  task automatic ev(input int k);
    case (k)
      0: wdog <= 1'b1;
      1: badop <= 1'b1;
      2: stopx <= 1'b1;
      3: badad <= 1'b1;
      4: brk <= 1'b1;
      5: tbr <= 1'b1;
      6: irq_n <= 1'b0;
      default: kbd_n <= 1'b0;
    endcase
    // pins pass a synchroniser, so hold them low a while
    repeat (k > 5 ? 4 : 1) @(posedge i_clk);
    {wdog, badop, stopx, badad, brk, tbr} <= 6'h00;
    {irq_n, kbd_n} <= 2'h3;
    @(posedge i_clk);
  endtask
  task automatic fetch();
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (vf !== 1'b1);
    @(posedge i_clk);
  endtask
  task automatic ext(input logic [7:0] l);
    pull <= 1'b1;
    plen <= l;
    @(posedge i_clk);
    pull <= 1'b0;
    @(posedge i_clk);
  endtask
  // ----------------------------
  // clock, watchdog, tests
  // ----------------------------
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end
  always @(posedge i_clk)
    if (sabort === 1'b1) seen_ab <= 1'b1;
  initial begin
    repeat (30000) @(posedge i_clk);
    fails++;
    print_verdict();
  end
  initial begin
    {psel, pen, pwr, pull, mon, lowsup, seen_ab} = '0;
    {wdog, badop, stopx, badad, brk, tbr} = '0;
    {irq_n, kbd_n, i_rst} = 3'h7;
    paddr = '0;
    pwdata = '0;
    plen = '0;
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    cause(32'(rst_seq_pkg::CAUSE_POR_VALUE));
    cause(32'h0);
    bus(1'b1, rst_seq_pkg::ADDR_CAUSE, 32'hff);
    chk(32'(err), 32'h1);
    bus(1'b0, 12'h00c, 32'h0);
    chk(32'(err), 32'h1);
    fetch();
    chk(32'(vec), 32'(rst_seq_pkg::VEC_RESET));
    bus(1'b1, rst_seq_pkg::ADDR_WDOG_CLR, 32'h0);
    bus(1'b1, rst_seq_pkg::ADDR_CONFIG, 32'h18);
    for (int k = 0; k < 4; k++) begin
      ev(k);
      fetch();
      chk(32'(vec), 32'(rst_seq_pkg::VEC_RESET));
      cause(32'h1 << pos[k]);
    end
    bus(1'b0, rst_seq_pkg::ADDR_CONFIG, 32'h0);
    chk(rd, 32'(rst_seq_pkg::CONFIG_RST));
    ev(0);
    fetch();
    ev(3);
    fetch();
    cause(32'h28);
    ev(0);
    ext(8'h5a);
    fetch();
    cause(32'h60);
    fetch();
    cause(32'h0);
    ext(8'h10);
    fetch();
    cause(32'h40);
    ext(8'h01);
    repeat (20) @(posedge i_clk);
    chk(32'(cpu_rst), 32'h0);
    mon <= 1'b1;
    ev(1);
    fetch();
    chk(32'(vec), 32'(rst_seq_pkg::VEC_RESET_MON));
    cause(32'h1 << rst_seq_pkg::POS_BAD_OP);
    mon <= 1'b0;
    bus(1'b1, rst_seq_pkg::ADDR_CONFIG, 32'h0f);
    for (int k = 0; k < 4; k++) begin
      ev(2);
      @(posedge i_clk);
      chk(32'(in_stop), 32'h1);
      ev(wk[k]);
      fetch();
      chk(32'(vec), 32'(wv[k]));
      chk(32'(n > 24 && n < 40), 32'h1);
    end
    bus(1'b1, rst_seq_pkg::ADDR_CONFIG, 32'h0a);
    ev(2);
    ev(5);
    repeat (50) @(posedge i_clk);
    chk(32'(in_stop), 32'h1);
    ev(6);
    fetch();
    chk(32'(n > 4090 && n < 4110), 32'h1);
    ev(2);
    lowsup <= 1'b1;
    repeat (50) @(posedge i_clk);
    lowsup <= 1'b0;
    fetch();
    chk(32'(n > 4150 && n < 4180), 32'h1);
    cause(32'h1 << rst_seq_pkg::POS_LOW_SUP);
    chk(32'(seen_ab), 32'h1);
    print_verdict();
  end
endmodule
`default_nettype wire
